// File: rtl/lid_pkg.sv
package lid_pkg;

	////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int          LID_CLK_KHZ        = 50000;
	localparam int          LID_SAMPLE_KHZ     = 10000;
	localparam int          LID_SAMPLE_DIV     = LID_CLK_KHZ / LID_SAMPLE_KHZ;
	localparam int          LID_OUT_KHZ        = 2222;
	localparam int          LID_SYNC_FMAX_HZ   = 4800;
	// phase word is 2^32 per cycle at the sample rate
	localparam logic [31:0] LID_SYNC_FWORD_MAX =
		32'((64'(LID_SYNC_FMAX_HZ) << 32) / (64'(LID_SAMPLE_KHZ) * 64'd1000));
	localparam int          LID_PHASE_FULL_MDEG = 360000;
	localparam int          LID_MDEG_FRAC       = 8;
	localparam logic [31:0] LID_MDEG_TO_PH      =
		32'((64'd1 << (32 + LID_MDEG_FRAC)) / 64'(LID_PHASE_FULL_MDEG));
	localparam logic [31:0] LID_PH_QUARTER      = 32'h4000_0000;

	////////////////////////////////////////////////////////////////////////////
	// widths and scales
	localparam int                 LID_STAGES   = 4;
	localparam logic signed [15:0] LID_FS_CODE  = 16'sh7FFF;
	localparam logic [6:0]         LID_EXP_X1   = 7'h01;
	localparam logic [6:0]         LID_EXP_X10  = 7'h0A;
	localparam logic [6:0]         LID_EXP_X100 = 7'h64;
	localparam logic [5:0]         LID_DIV_BITS = 6'h30;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] LID_REG_CTRL    = 8'h00;
	localparam logic [7:0] LID_REG_TC      = 8'h04;
	localparam logic [7:0] LID_REG_SENS    = 8'h08;
	localparam logic [7:0] LID_REG_FREQ    = 8'h0C;
	localparam logic [7:0] LID_REG_PHASE   = 8'h10;
	localparam logic [7:0] LID_REG_GAIN    = 8'h14;
	localparam logic [7:0] LID_REG_XOFS    = 8'h18;
	localparam logic [7:0] LID_REG_YOFS    = 8'h1C;
	localparam logic [7:0] LID_REG_STAT    = 8'h20;
	localparam logic [7:0] LID_REG_XRAW_LO = 8'h24;
	localparam logic [7:0] LID_REG_XRAW_HI = 8'h28;
	localparam logic [7:0] LID_REG_YRAW_LO = 8'h2C;
	localparam logic [7:0] LID_REG_YRAW_HI = 8'h30;
	localparam logic [7:0] LID_REG_DISP    = 8'h34;

	////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int LID_CTRL_STG  = 0;
	localparam int LID_CTRL_ADV  = 2;
	localparam int LID_CTRL_SYNC = 3;
	localparam int LID_CTRL_EXP  = 4;
	localparam int LID_ST_XOVL   = 0;
	localparam int LID_ST_YOVL   = 1;
	localparam int LID_ST_SERR   = 2;
	localparam int LID_ST_SACT   = 3;
	localparam int LID_DISP_Y    = 16;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [4:0]  LID_TC_RST    = 5'h08;
	localparam logic [5:0]  LID_SENS_RST  = 6'h10;
	localparam logic [15:0] LID_GAIN_RST  = 16'h0001;
	localparam logic [31:0] LID_FREQ_RST  = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} lid_wb_req_s;

	typedef struct packed {
		logic               ovl;
		logic signed [15:0] code;
	} lid_ch_s;

	typedef struct packed {
		lid_ch_s x;
		lid_ch_s y;
	} lid_dac_s;

	typedef struct packed {
		logic        neg;
		logic [32:0] rem;
		logic [47:0] dq;
	} lid_div_s;

endpackage : lid_pkg

// File: rtl/lid_sine_rom.sv
`timescale 1ns/1ps
module lid_sine_rom (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic [5:0]         ph_a_i,
	input  wire logic [5:0]         ph_b_i,
	output logic signed [15:0]      sin_a_o,
	output logic signed [15:0]      sin_b_o
);
	import lid_pkg::*;

	typedef struct packed {
		logic signed [15:0] a;
		logic signed [15:0] b;
	} lid_rom_s;

	// quarter wave, sampled at bin centres so no entry is zero or full scale
	localparam logic [15:0] LID_SINE_TAB [16] = '{
		16'h0648, 16'h12C8, 16'h1F1A, 16'h2B1F, 16'h36BA, 16'h41CE, 16'h4C3F, 16'h55F5,
		16'h5ED7, 16'h66CF, 16'h6DC9, 16'h73B5, 16'h7884, 16'h7C29, 16'h7E9D, 16'h7FD8
	};

	lid_rom_s st;
	lid_rom_s next_st;

	// quadrant fold: odd quadrants mirror the index, upper half negates
	function automatic logic signed [15:0] lid_sine(input logic [5:0] ph);
		logic [3:0]  idx;
		logic [15:0] mag;
		idx = ph[4] ? ~ph[3:0] : ph[3:0];
		mag = LID_SINE_TAB[idx];
		lid_sine = ph[5] ? -$signed(mag) : $signed(mag);
	endfunction : lid_sine

	////////////////////////////////////////////////////////////////////////////
	// registered lookup for both references
	always_comb begin
		next_st   = st;
		next_st.a = lid_sine(ph_a_i);
		next_st.b = lid_sine(ph_b_i);
		if (rst_i) begin
			next_st = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	assign sin_a_o = st.a;
	assign sin_b_o = st.b;

endmodule : lid_sine_rom

// File: rtl/lid_detector.sv
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module lid_detector (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire lid_pkg::lid_wb_req_s wb_req_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic signed [15:0]  adc_data_i,
	output logic                     adc_conv_o,
	output lid_pkg::lid_dac_s        dac_o,
	output logic                     dac_strobe_o,
	output logic                     sync_err_o,
	output logic                     sync_act_o
);
	import lid_pkg::*;

	typedef logic signed [47:0] lid_val_t;

	typedef struct packed {
		logic                              ack;
		logic [31:0]                       rdat;
		logic [1:0]                        stg;
		logic                              adv;
		logic                              sync_en;
		logic [1:0]                        expand;
		logic [4:0]                        tc;
		logic [5:0]                        sens;
		logic [31:0]                       freq;
		logic [18:0]                       phofs;
		logic [15:0]                       gain;
		logic signed [15:0]                xofs;
		logic signed [15:0]                yofs;
		logic                              sync_err;
		logic                              sync_act;
		logic [2:0]                        div5;
		logic [31:0]                       ph;
		logic                              wrap;
		logic                              conv;
		logic signed [15:0]                adc;
		logic signed [31:0]                px;
		logic signed [31:0]                py;
		lid_val_t                          sx;
		lid_val_t                          sy;
		logic [LID_STAGES-1:0][47:0]       lpx;
		logic [LID_STAGES-1:0][47:0]       lpy;
		logic                              primed;
		lid_val_t                          sum_x;
		lid_val_t                          sum_y;
		logic [31:0]                       cnt;
		lid_div_s                          dx;
		lid_div_s                          dy;
		logic [31:0]                       dvs;
		logic [5:0]                        dcnt;
		logic                              dbusy;
		lid_val_t                          syx;
		lid_val_t                          syy;
		logic [15:0]                       oacc;
		lid_dac_s                          dac;
		logic                              strobe;
		lid_val_t                          rawx;
		lid_val_t                          rawy;
	} lid_state_s;

	lid_state_s         st;
	lid_state_s         next_st;
	logic [31:0]        ph_ofs;
	logic [31:0]        ph_i;
	logic [31:0]        ph_q;
	logic signed [15:0] sin_i;
	logic signed [15:0] sin_q;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// register readback, also the base word for byte-lane merges
	function automatic logic [31:0] lid_read(input lid_state_s s, input logic [7:0] adr);
		logic [31:0] r;
		r = 32'h0;
		case ({adr[7:2], 2'b00})
			LID_REG_CTRL: begin
				r[LID_CTRL_STG +: 2]  = s.stg;
				r[LID_CTRL_ADV]       = s.adv;
				r[LID_CTRL_SYNC]      = s.sync_en;
				r[LID_CTRL_EXP +: 2]  = s.expand;
			end
			LID_REG_TC:      r[4:0]   = s.tc;
			LID_REG_SENS:    r[5:0]   = s.sens;
			LID_REG_FREQ:    r        = s.freq;
			LID_REG_PHASE:   r[18:0]  = s.phofs;
			LID_REG_GAIN:    r[15:0]  = s.gain;
			LID_REG_XOFS:    r[15:0]  = s.xofs;
			LID_REG_YOFS:    r[15:0]  = s.yofs;
			LID_REG_STAT: begin
				r[LID_ST_XOVL] = s.dac.x.ovl;
				r[LID_ST_YOVL] = s.dac.y.ovl;
				r[LID_ST_SERR] = s.sync_err;
				r[LID_ST_SACT] = s.sync_act;
			end
			LID_REG_XRAW_LO: r        = s.rawx[31:0];
			LID_REG_XRAW_HI: r[15:0]  = s.rawx[47:32];
			LID_REG_YRAW_LO: r        = s.rawy[31:0];
			LID_REG_YRAW_HI: r[15:0]  = s.rawy[47:32];
			LID_REG_DISP: begin
				r[15:0]            = s.dac.x.code;
				r[LID_DISP_Y +: 16] = s.dac.y.code;
			end
			default:         r        = 32'h0;
		endcase
		lid_read = r;
	endfunction : lid_read

	// symmetric pin to the full-scale codes
	function automatic lid_ch_s lid_clamp(input logic signed [55:0] v);
		logic signed [55:0] fs;
		fs = 56'(LID_FS_CODE);
		lid_clamp.ovl  = (v > fs) || (v < -fs);
		lid_clamp.code = (v > fs) ? LID_FS_CODE : (v < -fs) ? -LID_FS_CODE : 16'(v);
	endfunction : lid_clamp

	// full-scale normalise, subtract offset, expand
	function automatic logic signed [55:0] lid_scale(input lid_val_t v, input logic [5:0] sens,
			input logic signed [15:0] ofs, input logic [1:0] expand);
		logic signed [55:0] d;
		logic [6:0]         m;
		d = (56'(v) >>> sens) - 56'(ofs);
		case (expand)
			2'h1:    m = LID_EXP_X10;
			2'h2:    m = LID_EXP_X100;
			default: m = LID_EXP_X1;
		endcase
		lid_scale = 56'(d * $signed({1'b0, m}));
	endfunction : lid_scale

	// one single-pole section; the shift is the time constant
	function automatic lid_val_t lid_lp(input lid_val_t x, input lid_val_t y, input logic [4:0] sh);
		lid_lp = y + ((x - y) >>> sh);
	endfunction : lid_lp

	// one restoring division step, quotient shifts into the low bits
	function automatic lid_div_s lid_div_step(input lid_div_s d, input logic [31:0] dvs);
		logic [32:0] r;
		r = {d.rem[31:0], d.dq[47]};
		lid_div_step    = d;
		lid_div_step.dq = {d.dq[46:0], 1'b0};
		if (r >= {1'b0, dvs}) begin
			lid_div_step.rem   = r - {1'b0, dvs};
			lid_div_step.dq[0] = 1'b1;
		end else begin
			lid_div_step.rem = r;
		end
	endfunction : lid_div_step

	// start a period average: magnitude and sign apart
	function automatic lid_div_s lid_div_load(input lid_val_t sum);
		lid_div_load.neg = sum[47];
		lid_div_load.rem = 33'h0;
		lid_div_load.dq  = sum[47] ? 48'(-sum) : 48'(sum);
	endfunction : lid_div_load

	////////////////////////////////////////////////////////////////////////////
	// reference phases; only the top bits reach the table
	assign ph_ofs = 32'((64'(st.phofs) * 64'(LID_MDEG_TO_PH)) >> LID_MDEG_FRAC);
	assign ph_i   = st.ph + ph_ofs;
	assign ph_q   = ph_i - LID_PH_QUARTER;

	lid_sine_rom u_rom (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ph_a_i  (ph_i[31:26]),
		.ph_b_i  (ph_q[31:26]),
		.sin_a_o (sin_i),
		.sin_b_o (sin_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		logic [LID_STAGES-1:0][47:0] in_x;
		logic [LID_STAGES-1:0][47:0] in_y;
		logic [4:0]                  sh;
		logic [32:0]                 ph_sum;
		logic [31:0]                 wd;
		logic [16:0]                 oa;
		lid_ch_s                     cx;
		lid_ch_s                     cy;
		lid_val_t                    vx;
		lid_val_t                    vy;
		lid_val_t                    qx;
		lid_val_t                    qy;
		in_x   = '0;
		in_y   = '0;
		sh     = 5'h0;
		ph_sum = 33'h0;
		wd     = 32'h0;
		oa     = 17'h0;
		cx     = '0;
		cy     = '0;
		vx     = '0;
		vy     = '0;
		qx     = '0;
		qy     = '0;
		next_st        = st;
		next_st.conv   = 1'b0;
		next_st.strobe = 1'b0;

		// bus: answer one cycle after the request, commit on the ack edge
		next_st.ack = wb_req_i.cyc & wb_req_i.stb & ~st.ack;
		if (wb_req_i.cyc & wb_req_i.stb & ~st.ack) begin
			next_st.rdat = lid_read(st, wb_req_i.adr);
		end
		if (wb_req_i.cyc & wb_req_i.stb & st.ack & wb_req_i.we) begin
			wd = lid_read(st, wb_req_i.adr);
			for (int b = 0; b < 4; b++) begin
				if (wb_req_i.sel[b]) begin
					wd[8*b +: 8] = wb_req_i.dat[8*b +: 8];
				end
			end
			case ({wb_req_i.adr[7:2], 2'b00})
				LID_REG_CTRL: begin
					next_st.stg     = wd[LID_CTRL_STG +: 2];
					next_st.adv     = wd[LID_CTRL_ADV];
					next_st.sync_en = wd[LID_CTRL_SYNC];
					next_st.expand  = wd[LID_CTRL_EXP +: 2];
				end
				LID_REG_TC:    next_st.tc    = wd[4:0];
				LID_REG_SENS:  next_st.sens  = wd[5:0];
				LID_REG_FREQ:  next_st.freq  = wd;
				LID_REG_PHASE: next_st.phofs = wd[18:0];
				LID_REG_GAIN:  next_st.gain  = wd[15:0];
				LID_REG_XOFS:  next_st.xofs  = wd[15:0];
				LID_REG_YOFS:  next_st.yofs  = wd[15:0];
				// write one clears; a same-cycle saturation below still sets it
				LID_REG_STAT:  next_st.sync_err = st.sync_err & ~wb_req_i.dat[LID_ST_SERR];
				default: ;
			endcase
		end

		// sync filter only at or below its frequency ceiling
		next_st.sync_act = st.sync_en && (st.freq <= LID_SYNC_FWORD_MAX);

		// sample sequencer: five clocks per converter sample
		next_st.div5 = (st.div5 == 3'(LID_SAMPLE_DIV - 1)) ? 3'h0 : st.div5 + 3'h1;
		case (st.div5)
			3'h0: begin
				next_st.adc  = adc_data_i;
				next_st.conv = 1'b1;
				ph_sum       = {1'b0, st.ph} + {1'b0, st.freq};
				next_st.ph   = ph_sum[31:0];
				next_st.wrap = ph_sum[32];  // carry marks a new reference period
			end
			3'h1: begin
				next_st.px = st.adc * sin_i;
				next_st.py = st.adc * sin_q;
			end
			3'h2: begin
				// widen before the product so large gains keep their top bits
				next_st.sx = 48'(st.px) * 48'($signed({1'b0, st.gain}));
				next_st.sy = 48'(st.py) * 48'($signed({1'b0, st.gain}));
			end
			3'h3: begin
				// advanced mode halves the per-stage constant for faster settling
				sh   = (st.adv && st.tc != 5'h0) ? st.tc - 5'h1 : st.tc;
				in_x = {st.lpx[2], st.lpx[1], st.lpx[0], st.sx};
				in_y = {st.lpy[2], st.lpy[1], st.lpy[0], st.sy};
				for (int k = 0; k < LID_STAGES; k++) begin
					if (k <= int'(st.stg)) begin
						next_st.lpx[k] = lid_lp(in_x[k], st.lpx[k], sh);
						next_st.lpy[k] = lid_lp(in_y[k], st.lpy[k], sh);
					end else begin
						// idle stages track their input so enabling them is glitch free
						next_st.lpx[k] = in_x[k];
						next_st.lpy[k] = in_y[k];
					end
				end
			end
			3'h4: begin
				// integer conversion of the cascade output
				cx = lid_clamp(56'($signed(st.lpx[st.stg])) >>> st.sens);
				cy = lid_clamp(56'($signed(st.lpy[st.stg])) >>> st.sens);
				next_st.wrap = 1'b0;
				if (!st.sync_act) begin
					next_st.primed = 1'b0;
					next_st.sum_x  = '0;
					next_st.sum_y  = '0;
					next_st.cnt    = 32'h0;
				end else begin
					if (cx.ovl || cy.ovl || &st.cnt) begin
						next_st.sync_err = 1'b1;
					end
					if (st.wrap) begin
						// a full period is closed: average it if the divider is idle, the partial first one is dropped
						if (st.primed && !st.dbusy) begin
							next_st.dx    = lid_div_load(st.sum_x);
							next_st.dy    = lid_div_load(st.sum_y);
							next_st.dvs   = st.cnt;
							next_st.dcnt  = LID_DIV_BITS;
							next_st.dbusy = 1'b1;
						end
						next_st.primed = 1'b1;
						next_st.sum_x  = 48'(cx.code);
						next_st.sum_y  = 48'(cy.code);
						next_st.cnt    = 32'h1;
					end else if (!(&st.cnt)) begin
						next_st.sum_x = st.sum_x + 48'(cx.code);
						next_st.sum_y = st.sum_y + 48'(cy.code);
						next_st.cnt   = st.cnt + 32'h1;
					end
				end
			end
			default: ;
		endcase

		// period divider: one quotient bit per clock for 48 clocks, far shorter than a period even at the sync ceiling
		if (st.dbusy) begin
			if (st.dcnt != 6'h0) begin
				next_st.dx   = lid_div_step(st.dx, st.dvs);
				next_st.dy   = lid_div_step(st.dy, st.dvs);
				next_st.dcnt = st.dcnt - 6'h1;
			end else begin
				qx = st.dx.neg ? -$signed(st.dx.dq) : $signed(st.dx.dq);
				qy = st.dy.neg ? -$signed(st.dy.dq) : $signed(st.dy.dq);
				next_st.syx   = qx <<< st.sens;
				next_st.syy   = qy <<< st.sens;
				next_st.dbusy = 1'b0;
			end
		end

		// output refresh: fractional divider at the output rate
		oa = {1'b0, st.oacc} + 17'(LID_OUT_KHZ);
		if (oa >= 17'(LID_CLK_KHZ)) begin
			next_st.oacc   = 16'(oa - 17'(LID_CLK_KHZ));
			next_st.strobe = 1'b1;
			vx = st.sync_act ? st.syx : $signed(st.lpx[st.stg]);
			vy = st.sync_act ? st.syy : $signed(st.lpy[st.stg]);
			next_st.rawx  = vx;
			next_st.rawy  = vy;
			next_st.dac.x = lid_clamp(lid_scale(vx, st.sens, st.xofs, st.expand));
			next_st.dac.y = lid_clamp(lid_scale(vy, st.sens, st.yofs, st.expand));
		end else begin
			next_st.oacc = 16'(oa);
		end

		if (rst_i) begin
			next_st      = '0;
			next_st.tc   = LID_TC_RST;
			next_st.sens = LID_SENS_RST;
			next_st.gain = LID_GAIN_RST;
			next_st.freq = LID_FREQ_RST;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register
	assign wb_dat_o     = st.rdat;
	assign wb_ack_o     = st.ack;
	assign adc_conv_o   = st.conv;
	assign dac_o        = st.dac;
	assign dac_strobe_o = st.strobe;
	assign sync_err_o   = st.sync_err;
	assign sync_act_o   = st.sync_act;

endmodule : lid_detector

// File: sim/lid_detector_assertions.sv
`timescale 1ns/1ps
module lid_detector_assertions import lid_pkg::*; (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire lid_wb_req_s wb_req_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [15:0] adc_data_i,
	input wire logic        adc_conv_o,
	input wire lid_dac_s    dac_o,
	input wire logic        dac_strobe_o,
	input wire logic        sync_err_o,
	input wire logic        sync_act_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////
	// bus answers once, next cycle, and read data rests between answers
	property p_ack_once;
		wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("bus ack not a single next-cycle pulse");
	property p_dat_hold;
		!wb_ack_o |-> $stable(wb_dat_o);
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");

	////////////////////////////////////////////////////////////////////////////
	// sample cadence and output refresh spacing
	property p_conv;
		adc_conv_o |=> (!adc_conv_o)[*4] ##1 adc_conv_o;
	endproperty
	a_conv: assert property (p_conv) else $error("conversion strobe not every five clocks");
	property p_strobe;
		dac_strobe_o |=> (!dac_strobe_o)[*8] ##[14:15] dac_strobe_o;
	endproperty
	a_strobe: assert property (p_strobe) else $error("output refresh spacing wrong");
	property p_dac_hold;
		!dac_strobe_o |-> $stable(dac_o);
	endproperty
	a_dac_hold: assert property (p_dac_hold) else $error("output codes moved between strobes");

	////////////////////////////////////////////////////////////////////////////
	// overload pins the code at a full-scale end, on x the matching one
	property p_x_pos;
		dac_o.x.ovl && !dac_o.x.code[15] |-> dac_o.x.code == LID_FS_CODE;
	endproperty
	a_x_pos: assert property (p_x_pos) else $error("x positive overload not clamped");
	property p_x_neg;
		dac_o.x.ovl && dac_o.x.code[15] |-> dac_o.x.code == -LID_FS_CODE;
	endproperty
	a_x_neg: assert property (p_x_neg) else $error("x negative overload not clamped");
	property p_y_clamp;
		dac_o.y.ovl |-> dac_o.y.code == LID_FS_CODE || dac_o.y.code == -LID_FS_CODE;
	endproperty
	a_y_clamp: assert property (p_y_clamp) else $error("y overload not clamped");
	property p_no_min;
		dac_o.x.code != 16'sh8000 && dac_o.y.code != 16'sh8000;
	endproperty
	a_no_min: assert property (p_no_min) else $error("asymmetric minimum code seen");

	c_ovl: cover property (dac_o.x.ovl && dac_strobe_o);
	c_sact: cover property (sync_act_o);
	c_serr: cover property ($rose(sync_err_o));
endmodule : lid_detector_assertions

// File: sim/lid_adc_model.sv
`timescale 1ns/1ps
module lid_adc_model (
	input  wire logic               clk_i,
	input  wire logic               adc_conv_i,
	input  wire logic signed [15:0] level_i,
	output logic signed [15:0]      adc_data_o
);
	// word is stale in the cycle after a conversion; show its inverse so a late capture is caught
	initial adc_data_o = '0;
	always @(posedge clk_i) begin
		adc_data_o <= adc_conv_i ? ~level_i : level_i;
	end
endmodule : lid_adc_model

// File: sim/lid_detector_tb_top.sv
`timescale 1ns/1ps
module lid_detector_tb_top;
	import lid_pkg::*;
	logic               clk_i = 1'b0;
	logic               rst_i;
	lid_wb_req_s        req;
	logic [31:0]        wb_dat_o;
	logic               wb_ack_o;
	logic signed [15:0] adc, lvl;
	logic               conv, strobe, serr, sact;
	lid_dac_s           dac;
	logic [31:0]        exp_q[$];
	logic [15:0]        rnd = 16'hBFF;
	int                 fails = 0;
	int                 compares = 0;
	int                 n;

	always #10 clk_i = ~clk_i;

	lid_detector uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.adc_data_i(adc), .adc_conv_o(conv), .dac_o(dac), .dac_strobe_o(strobe), .sync_err_o(serr),
		.sync_act_o(sact));
	lid_adc_model adc_m (.clk_i(clk_i), .adc_conv_i(conv), .level_i(lvl), .adc_data_o(adc));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	// 16-bit fibonacci lfsr, taps 16 14 13 11
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr

	task automatic wrap_up;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// one classic cycle; request held until ack is sampled, then idle a cycle
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		req <= '{1'b1, 1'b1, we, a, 4'hF, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		if (wb_ack_o !== 1'b1) begin
			fails++;
			wrap_up();
		end
		req <= '0;
		@(posedge clk_i);
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask : rd

	// count k output refreshes; fail and wrap up if they do not all come within 1200 clocks
	task automatic strobes(input int k);
		int c;
		c = 0;
		while (k > 0 && c < 40 * 30) begin
			@(posedge clk_i);
			c++;
			if (strobe === 1'b1) begin
				k--;
			end
		end
		chk(32'(k), 32'h0);
		if (k > 0) begin
			wrap_up();
		end
	endtask : strobes

	////////////////////////////////////////////////////////////////////////////
	// read checker: oldest note against data at each read ack
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && req.we === 1'b0) begin
			chk(wb_dat_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF);
		end
	end

	initial begin
		req = '0;
		lvl = '0;
		rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(LID_REG_TC, 32'(LID_TC_RST));
		rd(LID_REG_SENS, 32'(LID_SENS_RST));
		rd(LID_REG_GAIN, 32'(LID_GAIN_RST));
		rd(LID_REG_STAT, 32'h0);
		rd(8'hFC, 32'h0);
		rnd = lfsr(rnd);
		wb(1'b1, LID_REG_XOFS, {16'h0, rnd});
		rd(LID_REG_XOFS, {16'h0, rnd});
		wb(1'b1, LID_REG_XOFS, 32'h0);
		$display("test registers done");
		// in-phase near its peak, quadrature near its zero; this gain drives both far past full scale
		wb(1'b1, LID_REG_TC, 32'h2);
		wb(1'b1, LID_REG_SENS, 32'h0);
		wb(1'b1, LID_REG_GAIN, 32'h100);
		wb(1'b1, LID_REG_PHASE, 32'h15F90);
		for (int m = 0; m < 8; m++) begin
			wb(1'b1, LID_REG_CTRL, {29'h0, m[2:0]});
			lvl <= m[0] ? -16'sh4000 : 16'sh4000;
			strobes(14);
			chk(32'({dac.x.ovl, dac.y.ovl}), 32'h3);
			chk({dac.x.code, dac.y.code}, m[0] ? 32'h8001_7FFF : 32'h7FFF_8001);
			rd(LID_REG_DISP, m[0] ? 32'h7FFF_8001 : 32'h8001_7FFF);
			rd(LID_REG_STAT, 32'h3);
		end
		$display("test overload cascade done");
		wb(1'b1, LID_REG_CTRL, 32'h8);
		wb(1'b1, LID_REG_FREQ, LID_SYNC_FWORD_MAX);
		// active flag follows the frequency word one clock later
		@(posedge clk_i);
		chk(32'(sact), 32'h1);
		n = 0;
		while (serr !== 1'b1 && n < 30000) begin
			rnd = lfsr(rnd);
			lvl <= 16'sh4000 + $signed({8'h0, rnd[7:0]});
			@(posedge clk_i);
			n++;
		end
		chk(32'(serr), 32'h1);
		if (serr !== 1'b1) begin
			wrap_up();
		end
		wb(1'b1, LID_REG_FREQ, LID_SYNC_FWORD_MAX + 32'h1);
		@(posedge clk_i);
		chk(32'(sact), 32'h0);
		wb(1'b1, LID_REG_STAT, 32'h4);
		strobes(3);
		chk(32'(serr), 32'h0);
		rd(LID_REG_STAT, 32'h3);
		$display("test sync filter done");
		wrap_up();
	end
endmodule : lid_detector_tb_top

bind lid_detector lid_detector_assertions chk_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_data_i(adc_data_i), .adc_conv_o(adc_conv_o),
	.dac_o(dac_o), .dac_strobe_o(dac_strobe_o), .sync_err_o(sync_err_o), .sync_act_o(sync_act_o));
